// ---- gdc_host_model.sv ----
// Purpose: Motor controller model
// Assumes: One host word per call
// Notes:   Released words are inverted
module gdc_host_model (
    // Clock
    input  wire logic        clk_sys,
    // Host word port
    output logic             host_word_valid,
    output logic [15:0]      host_word,
    input  wire logic        resp_valid,
    input  wire logic [15:0] resp_word
);
    timeunit 1ns;
    timeprecision 1ps;

    // ==========
    // Word transfer
    initial host_word_valid = 1'b0;

    // One-cycle strobe, then invert the word
    task automatic send(input logic r, input logic [3:0] a, input logic [10:0] d);
        @(posedge clk_sys);
        host_word_valid <= 1'b1;
        host_word       <= {r, a, d};
        @(posedge clk_sys);
        host_word_valid <= 1'b0;
        host_word       <= ~host_word;
    endtask

    // Answer stands one cycle
    task automatic rd(input logic [3:0] a, output logic [15:0] d);
        send(1'b1, a, 11'h000);
        @(posedge clk_sys);
        d = resp_valid ? resp_word : 16'hxxxx;
    endtask
endmodule

// ---- gdc_pkg.sv ----
// Purpose: Shared constants for the gate driver control register bank
// Assumes: 200 MHz system clock, 16-bit host words delivered in parallel
// Notes:   All offsets, field positions, reset values and counts live here
package gdc_pkg;

    // ==========================================================
    // Host word layout
    localparam int HW_RW_BIT      = 15;
    localparam int HW_ADDR_MSB    = 14;
    localparam int HW_ADDR_LSB    = 11;
    localparam int HW_DATA_MSB    = 10;

    // ==========================================================
    // Register addresses
    localparam logic [3:0] ADDR_DRIVER_CONTROL = 4'h2;
    localparam logic [3:0] ADDR_HS_GATE_CONFIG = 4'h3;
    localparam logic [3:0] ADDR_LS_GATE_CONFIG = 4'h4;

    // ==========================================================
    // Reset values and writable masks (reserved bits read as zero)
    localparam logic [10:0] RST_DRIVER_CONTROL = 11'h000;
    localparam logic [10:0] RST_HS_GATE_CONFIG = 11'h377;
    localparam logic [10:0] RST_LS_GATE_CONFIG = 11'h777;
    localparam logic [10:0] MASK_DRIVER_CONTROL = 11'h3ff;
    localparam logic [10:0] MASK_HS_GATE_CONFIG = 11'h777;
    localparam logic [10:0] MASK_LS_GATE_CONFIG = 11'h777;
    localparam logic [10:0] MASK_LOCKED_DRV     = 11'h007;

    // ==========================================================
    // Driver control field positions
    localparam int DC_PUMP_UV_DIS  = 9;
    localparam int DC_GATE_F_DIS   = 8;
    localparam int DC_OTW_REPORT   = 7;
    localparam int DC_MODE_MSB     = 6;
    localparam int DC_MODE_LSB     = 5;
    localparam int DC_FREEWHEEL    = 4;
    localparam int DC_DIRECTION    = 3;
    localparam int DC_COAST        = 2;
    localparam int DC_BRAKE        = 1;
    localparam int DC_FAULT_CLEAR  = 0;

    // Gate config field positions
    localparam int GC_LOCK_MSB     = 10;
    localparam int GC_LOCK_LSB     = 8;
    localparam int GC_AUTOCLEAR    = 10;
    localparam int GC_PEAK_DRIVE_DURATION_MSB   = 9;
    localparam int GC_PEAK_DRIVE_DURATION_LSB   = 8;
    localparam int GC_SRC_MSB      = 6;
    localparam int GC_SRC_LSB      = 4;
    localparam int GC_SNK_MSB      = 2;
    localparam int GC_SNK_LSB      = 0;

    // ==========================================================
    // Lock codes and overcurrent response codes
    localparam logic [2:0] LOCK_CODE   = 3'h6;
    localparam logic [2:0] UNLOCK_CODE = 3'h3;
    localparam logic [1:0] OCR_RETRY   = 2'h1;

    // Input scheme encodings
    typedef enum logic [1:0] {
        GDC_MODE_SIX   = 2'b00,
        GDC_MODE_THREE = 2'b01,
        GDC_MODE_ONE   = 2'b10,
        GDC_MODE_INDEP = 2'b11
    } gdc_mode_t;

    // ==========================================================
    // Peak drive durations
    localparam int CLK_PERIOD_PS   = 5000;
    localparam int TDRIVE0_NS      = 500;
    localparam int TDRIVE1_NS      = 1000;
    localparam int TDRIVE2_NS      = 2000;
    localparam int TDRIVE3_NS      = 4000;
    localparam logic [9:0] TDRIVE0_CYC = 10'((TDRIVE0_NS * 1000) / CLK_PERIOD_PS);
    localparam logic [9:0] TDRIVE1_CYC = 10'((TDRIVE1_NS * 1000) / CLK_PERIOD_PS);
    localparam logic [9:0] TDRIVE2_CYC = 10'((TDRIVE2_NS * 1000) / CLK_PERIOD_PS);
    localparam logic [9:0] TDRIVE3_CYC = 10'((TDRIVE3_NS * 1000) / CLK_PERIOD_PS);

endpackage

// ---- gdc_regs.sv ----
// Purpose: Control register bank and drive logic of a three-phase gate driver
// Assumes: Host words arrive whole on a parallel strobe; inputs synchronous
// Notes:   Response to a read appears one cycle after the strobe

// Contract
// RULE_01: Bit 9 set suppresses pump undervoltage fault
// RULE_02: Bit 8 set ignores gate drive faults
// RULE_03: Bit 7 gates overtemp warning onto fault
// RULE_04: Bits 6-5 select input scheme
// RULE_05: Single-input: bit 4 picks diode freewheeling
// RULE_06: Single-input direction is bit 3 OR pin
// RULE_07: Bit 2 set turns all switches off
// RULE_08: Bit 1 OR pin brakes all low sides; the code brakes only in the single-input scheme
// RULE_09: Bit 0 clears latched faults, self-clears
// RULE_10: Lock code 110b blocks most writes
// RULE_11: Unlocked, other lock values are ignored
// RULE_12: Unlock code 011b re-enables writes
// RULE_13: Locked, other lock values are ignored
// RULE_14: Driver control resets to 0x00
// RULE_15: High-side config resets to 0x377
// RULE_16: Low-side config resets to 0x777
// RULE_17: Source code maps to peak source mA
// RULE_18: Sink code maps to peak sink mA
// RULE_19: Auto-clear overcurrent on next input pulse
// RULE_20: Bits 9-8 set peak drive time
// RULE_21: Summary fault ORs reports; pin mirrors
// RULE_22: 16-bit word: flag, address, data
// RULE_23: Retry is overcurrent response code 01b
// RULE_24: Reserved read zero; locked writes keep contents
// RULE_25: Host unlocks before changes, locks after
module gdc_regs (
    // Clock and reset
    input  wire logic        clk_sys,
    input  wire logic        arst_n,
    // Host word port
    input  wire logic        host_word_valid,
    input  wire logic [15:0] host_word,
    output logic             resp_valid,
    output logic [15:0]      resp_word,
    // Gate inputs, index 0..2 is phase A..C
    input  wire logic [2:0]  in_high,
    input  wire logic [2:0]  in_low,
    // Fault sources
    input  wire logic        pump_uv,
    input  wire logic        gate_fault,
    input  wire logic        overtemp_warning,
    input  wire logic        drain_source_overcurrent,
    input  wire logic        shunt_overcurrent,
    input  wire logic [1:0]  overcurrent_response,
    // Switch commands
    output logic [2:0]       gate_high_on,
    output logic [2:0]       gate_low_on,
    // Gate current settings and peak drive window
    output logic [8:0]       hs_source_ma,
    output logic [8:0]       hs_sink_ma,
    output logic [8:0]       ls_source_ma,
    output logic [8:0]       ls_sink_ma,
    output logic             peak_drive_active,
    // Fault reporting
    output logic [3:0]       fault_latched,
    output logic             fault_summary,
    output logic             fault_out_n,
    output logic             locked
);

    // ==========================================================
    // Functions
    // Source current in mA; sink is exactly twice the source figure
    function automatic logic [8:0] source_ma(input logic [2:0] code);
        logic [8:0] ma;
        case (code)
            3'h0:    ma = 9'd15;
            3'h1:    ma = 9'd15;
            3'h2:    ma = 9'd45;
            3'h3:    ma = 9'd60;
            3'h4:    ma = 9'd90;
            3'h5:    ma = 9'd105;
            3'h6:    ma = 9'd135;
            default: ma = 9'd150;
        endcase
        return ma;
    endfunction

    function automatic logic [8:0] sink_ma(input logic [2:0] code);
        logic [8:0] ma;
        ma = source_ma(code);
        return {ma[7:0], 1'b0};
    endfunction

    // ==========================================================
    // Host word decode
    logic        wr_stb;
    logic        rd_stb;
    logic [3:0]  word_addr;
    logic [10:0] word_data;
    logic [2:0]  wr_lock;

    assign wr_stb    = host_word_valid & ~host_word[gdc_pkg::HW_RW_BIT];  // RULE_22
    assign rd_stb    = host_word_valid & host_word[gdc_pkg::HW_RW_BIT];   // RULE_22
    assign word_addr = host_word[gdc_pkg::HW_ADDR_MSB:gdc_pkg::HW_ADDR_LSB];
    assign word_data = host_word[gdc_pkg::HW_DATA_MSB:0];
    assign wr_lock   = word_data[gdc_pkg::GC_LOCK_MSB:gdc_pkg::GC_LOCK_LSB];

    // ==========================================================
    // Register storage
    logic [10:0] driver_control;
    logic [10:0] high_side_gate_config;
    logic [10:0] low_side_gate_config;

    // Lock state follows only the two exact codes
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            locked <= 1'b0;
        end else if (wr_stb && word_addr == gdc_pkg::ADDR_HS_GATE_CONFIG) begin
            if (!locked && wr_lock == gdc_pkg::LOCK_CODE) begin
                locked <= 1'b1;                                 // RULE_10 RULE_11
            end else if (locked && wr_lock == gdc_pkg::UNLOCK_CODE) begin
                locked <= 1'b0;                                 // RULE_12 RULE_13
            end
        end
    end

    // Driver control; only the low three bits pass while locked
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            driver_control <= gdc_pkg::RST_DRIVER_CONTROL;      // RULE_14
        end else if (wr_stb && word_addr == gdc_pkg::ADDR_DRIVER_CONTROL) begin
            if (locked) begin
                driver_control <= (driver_control & ~gdc_pkg::MASK_LOCKED_DRV)
                                | (word_data & gdc_pkg::MASK_LOCKED_DRV);  // RULE_10
            end else begin
                driver_control <= word_data & gdc_pkg::MASK_DRIVER_CONTROL; // RULE_24
            end
        end else begin
            driver_control[gdc_pkg::DC_FAULT_CLEAR] <= 1'b0;    // RULE_09
        end
    end

    // High-side config; lock field tracks the lock state itself
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            high_side_gate_config <= gdc_pkg::RST_HS_GATE_CONFIG;  // RULE_15
        end else if (wr_stb && word_addr == gdc_pkg::ADDR_HS_GATE_CONFIG) begin
            if (!locked) begin
                high_side_gate_config[7:0] <= word_data[7:0]
                                            & gdc_pkg::MASK_HS_GATE_CONFIG[7:0]; // RULE_24
            end
            if (!locked && wr_lock == gdc_pkg::LOCK_CODE) begin
                high_side_gate_config[10:8] <= gdc_pkg::LOCK_CODE;   // RULE_10
            end else if (locked && wr_lock == gdc_pkg::UNLOCK_CODE) begin
                high_side_gate_config[10:8] <= gdc_pkg::UNLOCK_CODE; // RULE_12
            end
        end
    end

    // Low-side config; whole register frozen while locked
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            low_side_gate_config <= gdc_pkg::RST_LS_GATE_CONFIG;   // RULE_16
        end else if (wr_stb && !locked
                     && word_addr == gdc_pkg::ADDR_LS_GATE_CONFIG) begin
            low_side_gate_config <= word_data & gdc_pkg::MASK_LS_GATE_CONFIG; // RULE_10 RULE_24
        end
    end

    // ==========================================================
    // Read response, unmapped addresses answer zero
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            resp_valid <= 1'b0;
            resp_word  <= 16'h0000;
        end else begin
            resp_valid <= rd_stb;
            if (rd_stb) begin
                case (word_addr)
                    gdc_pkg::ADDR_DRIVER_CONTROL: resp_word <= {5'h00, driver_control};
                    gdc_pkg::ADDR_HS_GATE_CONFIG: resp_word <= {5'h00, high_side_gate_config};
                    gdc_pkg::ADDR_LS_GATE_CONFIG: resp_word <= {5'h00, low_side_gate_config};
                    default:                      resp_word <= 16'h0000;  // RULE_22
                endcase
            end
        end
    end

    // ==========================================================
    // Field views
    gdc_pkg::gdc_mode_t mode;
    logic        fault_clear;
    logic        dir_eff;
    logic        brake_eff;
    logic [2:0]  any_input;
    logic [2:0]  prev_input;
    logic        input_pulse;
    logic        retry_autoclear;

    assign mode        = gdc_pkg::gdc_mode_t'(
                         driver_control[gdc_pkg::DC_MODE_MSB:gdc_pkg::DC_MODE_LSB]); // RULE_04
    assign fault_clear = driver_control[gdc_pkg::DC_FAULT_CLEAR];                   // RULE_09
    assign dir_eff     = driver_control[gdc_pkg::DC_DIRECTION] | in_high[2];        // RULE_06
    assign brake_eff   = driver_control[gdc_pkg::DC_BRAKE] | in_low[2];             // RULE_08
    assign any_input   = in_high | in_low;
    assign input_pulse = |(any_input & ~prev_input);
    assign retry_autoclear = low_side_gate_config[gdc_pkg::GC_AUTOCLEAR]
                           && overcurrent_response == gdc_pkg::OCR_RETRY
                           && input_pulse;                                          // RULE_19 RULE_23

    // Input history for pulse edge detection
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            prev_input <= 3'h0;
        end else begin
            prev_input <= any_input;
        end
    end

    // ==========================================================
    // Latched faults: [0] pump uv, [1] gate, [2] drain-source oc, [3] shunt oc
    // A new fault in the clearing cycle wins over the clear
    logic [3:0] fault_set;
    logic [3:0] fault_clr;

    assign fault_set = {shunt_overcurrent,
                        drain_source_overcurrent,
                        gate_fault & ~driver_control[gdc_pkg::DC_GATE_F_DIS],    // RULE_02
                        pump_uv & ~driver_control[gdc_pkg::DC_PUMP_UV_DIS]};     // RULE_01
    assign fault_clr = {4{fault_clear}} | {{2{retry_autoclear}}, 2'b00};         // RULE_09 RULE_19

    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            fault_latched <= 4'h0;
        end else begin
            fault_latched <= fault_set | (fault_latched & ~fault_clr);
        end
    end

    // Summary and pin; warning reported only when enabled
    logic next_summary;

    assign next_summary = (|fault_latched)
                        | (overtemp_warning & driver_control[gdc_pkg::DC_OTW_REPORT]); // RULE_03

    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            fault_summary <= 1'b0;
            fault_out_n   <= 1'b1;
        end else begin
            fault_summary <= next_summary;   // RULE_21
            fault_out_n   <= ~next_summary;  // RULE_21
        end
    end

    // ==========================================================
    // Single-input commutation from three hall lines
    logic [2:0] hall;
    logic [2:0] one_high;
    logic [2:0] one_low;

    assign hall = {in_low[1], in_high[1], in_low[0]};

    always_comb begin
        logic [2:0] drive_hi;
        logic [2:0] drive_lo;
        drive_hi = 3'h0;
        drive_lo = 3'h0;
        case (hall)
            3'h1:    begin drive_hi = 3'b001; drive_lo = 3'b010; end
            3'h3:    begin drive_hi = 3'b001; drive_lo = 3'b100; end
            3'h2:    begin drive_hi = 3'b010; drive_lo = 3'b100; end
            3'h6:    begin drive_hi = 3'b010; drive_lo = 3'b001; end
            3'h4:    begin drive_hi = 3'b100; drive_lo = 3'b001; end
            3'h5:    begin drive_hi = 3'b100; drive_lo = 3'b010; end
            default: begin drive_hi = 3'h0;   drive_lo = 3'h0;   end
        endcase
        // Reverse direction swaps which switch of a leg conducts
        if (dir_eff) begin
            one_high = drive_lo & {3{in_high[0]}};
            one_low  = drive_hi;
            if (!driver_control[gdc_pkg::DC_FREEWHEEL] && !in_high[0]) begin
                one_low = drive_hi | drive_lo;   // RULE_05
            end
        end else begin
            one_high = drive_hi & {3{in_high[0]}};
            one_low  = drive_lo;
            if (!driver_control[gdc_pkg::DC_FREEWHEEL] && !in_high[0]) begin
                one_low = drive_hi | drive_lo;   // RULE_05
            end
        end
        if (brake_eff) begin
            one_high = 3'h0;
            one_low  = 3'h7;                     // RULE_08
        end
    end

    // ==========================================================
    // Gate command; coast and latched faults force every switch off
    logic [2:0] next_high;
    logic [2:0] next_low;

    always_comb begin
        case (mode)
            gdc_pkg::GDC_MODE_SIX: begin
                next_high = in_high & ~in_low;    // Both requested is shoot-through
                next_low  = in_low & ~in_high;
            end
            gdc_pkg::GDC_MODE_THREE: begin
                next_high = in_high & in_low;     // Low input acts as leg enable
                next_low  = ~in_high & in_low;
            end
            gdc_pkg::GDC_MODE_ONE: begin
                next_high = one_high;
                next_low  = one_low;
            end
            gdc_pkg::GDC_MODE_INDEP: begin
                next_high = in_high;
                next_low  = in_low;
            end
            default: begin
                next_high = 3'h0;
                next_low  = 3'h0;
            end
        endcase
        if (driver_control[gdc_pkg::DC_COAST] || (|fault_latched)) begin
            next_high = 3'h0;                     // RULE_07
            next_low  = 3'h0;                     // RULE_07
        end
    end

    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            gate_high_on <= 3'h0;
            gate_low_on  <= 3'h0;
        end else begin
            gate_high_on <= next_high;
            gate_low_on  <= next_low;
        end
    end

    // ==========================================================
    // Gate current settings
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            hs_source_ma <= 9'd150;
            hs_sink_ma   <= 9'd300;
            ls_source_ma <= 9'd150;
            ls_sink_ma   <= 9'd300;
        end else begin
            hs_source_ma <= source_ma(high_side_gate_config[gdc_pkg::GC_SRC_MSB:gdc_pkg::GC_SRC_LSB]); // RULE_17
            hs_sink_ma   <= sink_ma(high_side_gate_config[gdc_pkg::GC_SNK_MSB:gdc_pkg::GC_SNK_LSB]);   // RULE_18
            ls_source_ma <= source_ma(low_side_gate_config[gdc_pkg::GC_SRC_MSB:gdc_pkg::GC_SRC_LSB]);  // RULE_17
            ls_sink_ma   <= sink_ma(low_side_gate_config[gdc_pkg::GC_SNK_MSB:gdc_pkg::GC_SNK_LSB]);    // RULE_18
        end
    end

    // ==========================================================
    // Peak drive window, restarted by any switch turning on
    logic [9:0] drive_len;
    logic [9:0] drive_cnt;
    logic       turn_on;

    always_comb begin
        case (low_side_gate_config[gdc_pkg::GC_PEAK_DRIVE_DURATION_MSB:gdc_pkg::GC_PEAK_DRIVE_DURATION_LSB])
            2'h0:    drive_len = gdc_pkg::TDRIVE0_CYC;   // RULE_20
            2'h1:    drive_len = gdc_pkg::TDRIVE1_CYC;   // RULE_20
            2'h2:    drive_len = gdc_pkg::TDRIVE2_CYC;   // RULE_20
            default: drive_len = gdc_pkg::TDRIVE3_CYC;   // RULE_20
        endcase
    end

    assign turn_on = |({next_high, next_low} & ~{gate_high_on, gate_low_on});

    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            drive_cnt         <= 10'h000;
            peak_drive_active <= 1'b0;
        end else if (turn_on) begin
            drive_cnt         <= drive_len - 10'h001;
            peak_drive_active <= 1'b1;
        end else if (drive_cnt != 10'h000) begin
            drive_cnt         <= drive_cnt - 10'h001;
        end else begin
            peak_drive_active <= 1'b0;
        end
    end

endmodule

// ---- gdc_regs_sva.sv ----
// Purpose: Port checks of the bank
// Assumes: One clock, async reset
// Notes:   Contents judged by reads
module gdc_regs_sva (
    // Clock, reset, host port
    input wire logic        clk_sys, arst_n, host_word_valid, resp_valid,
    input wire logic [15:0] host_word, resp_word,
    // Fault sources and outputs
    input wire logic        pump_uv, gate_fault, overtemp_warning,
    input wire logic        drain_source_overcurrent, shunt_overcurrent,
    input wire logic        fault_summary, fault_out_n, locked, peak_drive_active,
    input wire logic [2:0]  gate_high_on, gate_low_on,
    input wire logic [3:0]  fault_latched
);
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!arst_n);

    // ==========
    // Decoded host writes
    logic wr_dc, wr_hs, no_flt;
    logic [2:0] code;
    assign wr_dc  = host_word_valid && !host_word[15] && host_word[14:11] == 4'h2;
    assign wr_hs  = host_word_valid && !host_word[15] && host_word[14:11] == 4'h3;
    assign code   = host_word[10:8];
    assign no_flt = !(pump_uv || gate_fault || drain_source_overcurrent || shunt_overcurrent);

    // ==========
    // Host port and lock
    a_read_answer: assert property (host_word_valid && host_word[15] |=>
        resp_valid && resp_word[15:11] == 5'h00) else $error("no answer");
    a_resp_cause: assert property (resp_valid |->
        $past(host_word_valid && host_word[15])) else $error("stray answer");
    a_lock_set: assert property (wr_hs && code == 3'h6 |=> locked)
        else $error("no lock");
    a_lock_clear: assert property (wr_hs && code == 3'h3 |=> !locked)
        else $error("no unlock");
    a_lock_hold: assert property (!(wr_hs && (code == 3'h6 || code == 3'h3)) |=>
        locked == $past(locked)) else $error("lock moved");

    // Drive and faults
    a_coast_off: assert property (wr_dc && host_word[2] |=> ##1
        gate_high_on == 3'h0 && gate_low_on == 3'h0) else $error("coast failed");
    a_clear_faults: assert property (wr_dc && host_word[0] && no_flt |->
        ##[1:3] fault_latched == 4'h0) else $error("no clear");
    a_pin_mirror: assert property (fault_out_n != fault_summary)
        else $error("pin mismatch");
    a_summary_cause: assert property (fault_summary |-> $past(|fault_latched) ||
        $past(overtemp_warning)) else $error("no cause");
    a_peak_hold: assert property ($rose(peak_drive_active) |-> peak_drive_active[*8])
        else $error("short window");
endmodule

bind gdc_regs gdc_regs_sva u_sva (.*);

// ---- testbench.sv ----
// Purpose: Self-checking bench
// Assumes: 200 MHz clk_sys
// Notes:   Waits follow registered latencies
module testbench;
    timeunit 1ns;
    timeprecision 1ps;

    logic        clk_sys, arst_n, hv, rv, summ, fo_n, locked, peak;
    logic [15:0] hw, rw, rdata;
    logic [2:0]  in_high, in_low, gh, gl;
    logic [4:0]  flt; // Shunt, drain-source, overtemp, gate, pump
    logic [1:0]  ocr;
    logic [3:0]  latched;
    logic [8:0]  hs_src, hs_snk, ls_src, ls_snk;
    logic [10:0] d;
    int          n_fail = 0, samples_checked = 0, seed = 32'haab6, cnt;

    gdc_host_model host (.clk_sys, .host_word_valid(hv), .host_word(hw),
        .resp_valid(rv), .resp_word(rw));
    gdc_regs dut (.clk_sys, .arst_n, .host_word_valid(hv), .host_word(hw),
        .resp_valid(rv), .resp_word(rw), .in_high, .in_low,
        .pump_uv(flt[0]), .gate_fault(flt[1]), .overtemp_warning(flt[2]),
        .drain_source_overcurrent(flt[3]), .shunt_overcurrent(flt[4]),
        .overcurrent_response(ocr), .gate_high_on(gh), .gate_low_on(gl),
        .hs_source_ma(hs_src), .hs_sink_ma(hs_snk), .ls_source_ma(ls_src),
        .ls_sink_ma(ls_snk), .peak_drive_active(peak), .fault_latched(latched),
        .fault_summary(summ), .fault_out_n(fo_n), .locked);

    // ==========
    // Checks
    function automatic logic [15:0] ma(input logic [3:0] c);
        logic [15:0] t [16] = '{16'h0f, 16'h0f, 16'h2d, 16'h3c, 16'h5a, 16'h69, 16'h87, 16'h96,
            16'h1e, 16'h1e, 16'h5a, 16'h78, 16'hb4, 16'hd2, 16'h10e, 16'h12c};
        return t[c];
    endfunction
    task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
        samples_checked++;
        if (g !== e) begin
            n_fail++;
            $display("ERROR %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic rchk(input logic [3:0] a, input logic [10:0] e);
        host.rd(a, rdata);
        chk("read", {5'h00, e}, rdata);
    endtask
    task automatic wt(input int n);
        repeat (n) @(posedge clk_sys);
    endtask
    task automatic end_of_test();
        $display("checked %0d mismatches %0d", samples_checked, n_fail);
        if (n_fail == 0 && samples_checked > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask

    // ==========
    // Clock and watchdog
    initial begin
        clk_sys = 1'b0;
        forever #2.5 clk_sys = ~clk_sys;
    end
    initial begin
        wt(20000);
        n_fail++;
        end_of_test();
    end

    // ==========
    // Main sequence
    initial begin
        arst_n = 1'b0; in_high = 3'h0; in_low = 3'h0; flt = 5'h00; ocr = 2'h0;
        wt(5);
        arst_n <= 1'b1;
        chk("hs_src", ma(4'h7), {7'h00, hs_src});
        rchk(4'h2, 11'h000);
        rchk(4'h3, 11'h377);
        rchk(4'h4, 11'h777);
        rchk(4'h5, 11'h000);
        // Random settings, never locking
        for (int i = 0; i < 24; i++) begin
            d = 11'($random(seed));
            if (d[10:8] == 3'h6) d[10:8] = 3'h5;
            host.send(1'b0, 4'h3, d);
            host.send(1'b0, 4'h4, d);
            host.send(1'b0, 4'h2, d);
            rchk(4'h3, {3'h3, 1'b0, d[6:4], 1'b0, d[2:0]});
            rchk(4'h4, d & 11'h777);
            rchk(4'h2, d & 11'h3fe);
            chk("hs_src", ma({1'b0, d[6:4]}), {7'h00, hs_src});
            chk("ls_snk", ma({1'b1, d[2:0]}), {7'h00, ls_snk});
        end
        // Lock, refused writes, unlock
        host.send(1'b0, 4'h2, 11'h000);
        host.send(1'b0, 4'h4, 11'h123);
        host.send(1'b0, 4'h3, 11'h655);
        host.send(1'b0, 4'h4, 11'h000);
        chk("locked", 16'h1, {15'h0, locked});
        host.send(1'b0, 4'h2, 11'h3f4);
        host.send(1'b0, 4'h3, 11'h555);
        rchk(4'h4, 11'h123);
        rchk(4'h2, 11'h004);
        rchk(4'h3, 11'h655);
        host.send(1'b0, 4'h3, 11'h355);
        host.send(1'b0, 4'h4, 11'h400);
        rchk(4'h4, 11'h400);
        // Fault enables
        for (int i = 0; i < 3; i++)
            for (int en = 0; en < 2; en++) begin
                host.send(1'b0, 4'h2, 11'(en) << (9 - i));
                flt[i] <= 1'b1;
                wt(4);
                chk("summary", 16'((i == 2) ? en : 1 - en), {15'h0, summ});
                chk("fault_out_n", {15'h0, !summ}, {15'h0, fo_n});
                flt[i] <= 1'b0;
                host.send(1'b0, 4'h2, 11'h001);
                wt(4);
                chk("latched", 16'h0, {12'h0, latched});
            end
        // Brake by pin, by register, then coast
        for (int k = 0; k < 2; k++) begin
            in_low <= 3'(4 >> (2 * k));
            host.send(1'b0, 4'h2, 11'h040 | 11'(2 * k));
            wt(3);
            chk("gate_low", 16'h7, {13'h0, gl});
        end
        host.send(1'b0, 4'h2, 11'h044);
        wt(3);
        chk("gate_low", 16'h0, {13'h0, gl});
        // Direct schemes
        for (int k = 0; k < 2; k++) begin
            host.send(1'b0, 4'h2, 11'(k * 3) << 5);
            in_high <= 3'h1;
            in_low <= 3'h4;
            wt(3);
            chk("gate_pair", 16'h0104, {5'h0, gh, 5'h0, gl});
        end
        // Overcurrent auto-clear in retry only
        for (int k = 0; k < 2; k++) begin
            ocr <= 2'(1 - k);
            in_high <= 3'h0;
            flt[3] <= 1'b1;
            wt(2);
            flt[3] <= 1'b0;
            wt(2);
            in_high <= 3'h1;
            wt(3);
            chk("oc_latched", 16'(k), {15'h0, latched[2]});
            host.send(1'b0, 4'h2, 11'h001);
            wt(3);
        end
        // Peak window per duration code
        for (int k = 0; k < 4; k++) begin
            in_high <= 3'h0;
            host.send(1'b0, 4'h4, 11'(k) << 8);
            for (int j = 0; j < 1000 && peak; j++) wt(1);
            in_high <= 3'h1;
            for (int j = 0; j < 10 && !peak; j++) wt(1);
            for (cnt = 0; peak && cnt < 2000; cnt++) wt(1);
            chk("peak_cycles", 16'h0064 << k, 16'(cnt));
        end
        end_of_test();
    end
endmodule
